/* File: design/rsso_core.v */
`timescale 1ns/1ps
`include "rsso_consts.vh"
// Contract
// - rotate right moves the file value down one bit, old carry to bit 7, bit 0 to carry.
// - file address 0..127 is taken; destination 0 writes work, 1 writes the file.
// - literal op computes literal minus work and stores it in work.
// - after literal op carry is 1 when work <= literal, nibble carry likewise on bits 3:0.
// - file op computes file minus work, result to the selected destination.
// - after file op carry is 1 when work <= file, nibble carry when low nibbles compare so.
// - borrow op computes file minus work minus inverted carry and updates all three flags.
// - borrow op takes its borrow from carry and writes to the selected destination.
// - sleep loads the watchdog counter with zero and clears its prescaler.
// - sleep clears powerdown status, sets timeout status, and leaves other flags alone.
// - after sleep the core halts and its oscillator stops until a wake event.
module rsso_core (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire CLK_EN_I,
  input wire EXEC_I,
  input wire [2:0] OPCODE_I,
  input wire [6:0] FILE_ADDR_I,
  input wire DEST_I,
  input wire [7:0] LITERAL_I,
  input wire [7:0] FILE_DATA_I,
  input wire WAKE_I,
  output reg [7:0] WORK_O,
  output reg FILE_WE_O,
  output reg [6:0] FILE_WADDR_O,
  output reg [7:0] FILE_WDATA_O,
  output reg CARRY_O,
  output reg NIBBLE_CARRY_FLAG_O,
  output reg ZERO_O,
  output reg TIMEOUT_STATUS_N_O,
  output reg POWERDOWN_STATUS_N_O,
  output reg [7:0] WATCHDOG_COUNTER_O,
  output reg [7:0] WATCHDOG_PRESCALER_O,
  output reg HALTED_O,
  output reg OSC_RUN_O
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function is_sub;
    input [2:0] op;
    begin
      is_sub = (op == `RSSO_OP_SUBL) || (op == `RSSO_OP_SUBF) ||
               (op == `RSSO_OP_SUBFB);
    end
  endfunction

  wire [7:0] dog_cnt_w;
  wire [7:0] pre_w;
  wire asleep_w;
  // a halted core ignores new instructions until woken
  wire go = EXEC_I && !asleep_w;
  wire rotate_right_carry_op = go && (OPCODE_I == `RSSO_OP_ROTR);
  wire literal_minus_work_op = go && (OPCODE_I == `RSSO_OP_SUBL);
  wire file_minus_work_op = go && (OPCODE_I == `RSSO_OP_SUBF);
  wire file_minus_work_borrow_op = go && (OPCODE_I == `RSSO_OP_SUBFB);
  wire sleep_op = go && (OPCODE_I == `RSSO_OP_SLEEP);

  // ----------------------------------------
  // subtractor
  // ----------------------------------------
  wire [7:0] sub_a = literal_minus_work_op ? LITERAL_I : FILE_DATA_I;
  // plain subtracts run with no borrow; carry high means no borrow
  wire sub_borrow = file_minus_work_borrow_op ? CARRY_O : 1'b1;
  wire [7:0] diff;
  wire sub_c;
  wire sub_nc;
  wire sub_z;

  rsso_sub8 u_sub (
    .a_i(sub_a),
    .b_i(WORK_O),
    .borrow_i(sub_borrow),
    .diff_o(diff),
    .carry_o(sub_c),
    .nib_carry_o(sub_nc),
    .zero_o(sub_z)
  );

  rsso_sleep_ctl u_sleep (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CLK_EN_I),
    .sleep_i(sleep_op),
    .wake_i(WAKE_I),
    .dog_cnt_o(dog_cnt_w),
    .pre_o(pre_w),
    .asleep_o(asleep_w)
  );

  // ----------------------------------------
  // result and next state
  // ----------------------------------------
  wire [7:0] rot = {CARRY_O, FILE_DATA_I[`RSSO_MSB:1]};
  reg [7:0] result;
  reg to_file;
  reg wr_any;

  always @* begin
    result = diff;
    to_file = 1'b0;
    wr_any = 1'b0;
    if (rotate_right_carry_op) begin
      result = rot;
      wr_any = 1'b1;
      to_file = (DEST_I == `RSSO_DEST_FILE);
    end else if (literal_minus_work_op) begin
      wr_any = 1'b1;
    end else if (file_minus_work_op || file_minus_work_borrow_op) begin
      wr_any = 1'b1;
      to_file = (DEST_I == `RSSO_DEST_FILE);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WORK_O <= `RSSO_WORK_RST;
      FILE_WE_O <= 1'b0;
      FILE_WADDR_O <= 7'h00;
      FILE_WDATA_O <= 8'h00;
      CARRY_O <= `RSSO_FLAG_RST;
      NIBBLE_CARRY_FLAG_O <= `RSSO_FLAG_RST;
      ZERO_O <= `RSSO_FLAG_RST;
      TIMEOUT_STATUS_N_O <= `RSSO_STAT_N_RST;
      POWERDOWN_STATUS_N_O <= `RSSO_STAT_N_RST;
      WATCHDOG_COUNTER_O <= `RSSO_DOG_CLEAR;
      WATCHDOG_PRESCALER_O <= `RSSO_PRE_CLEAR;
      HALTED_O <= 1'b0;
      OSC_RUN_O <= 1'b1;
    end else if (CLK_EN_I) begin
      FILE_WE_O <= wr_any && to_file;
      WATCHDOG_COUNTER_O <= dog_cnt_w;
      WATCHDOG_PRESCALER_O <= pre_w;
      HALTED_O <= asleep_w;
      OSC_RUN_O <= !asleep_w;
      if (wr_any && to_file) begin
        FILE_WADDR_O <= FILE_ADDR_I;
        FILE_WDATA_O <= result;
      end
      if (wr_any && !to_file)
        WORK_O <= result;
      if (rotate_right_carry_op)
        CARRY_O <= FILE_DATA_I[0];
      if (is_sub(OPCODE_I) && go) begin
        CARRY_O <= sub_c;
        NIBBLE_CARRY_FLAG_O <= sub_nc;
        ZERO_O <= sub_z;
      end
      if (sleep_op) begin
        POWERDOWN_STATUS_N_O <= 1'b0;
        TIMEOUT_STATUS_N_O <= 1'b1;
      end
    end
  end
endmodule

/* File: design/rsso_sleep_ctl.v */
`timescale 1ns/1ps
`include "rsso_consts.vh"
// ----------------------------------------
// watchdog clear and sleep hold
// ----------------------------------------
module rsso_sleep_ctl (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire sleep_i,
  input wire wake_i,
  output reg [7:0] dog_cnt_o,
  output reg [7:0] pre_o,
  output reg asleep_o
);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dog_cnt_o <= `RSSO_DOG_CLEAR;
      pre_o <= `RSSO_PRE_CLEAR;
      asleep_o <= 1'b0;
    end else if (ce_i) begin
      if (sleep_i) begin
        dog_cnt_o <= `RSSO_DOG_CLEAR;
        pre_o <= `RSSO_PRE_CLEAR;
        asleep_o <= 1'b1;
      end else begin
        if (wake_i)
          asleep_o <= 1'b0;
        // prescaler counts, watchdog steps on its wrap
        pre_o <= pre_o + 8'h01;
        if (pre_o == 8'hff)
          dog_cnt_o <= dog_cnt_o + 8'h01;
      end
    end
  end
endmodule

/* File: design/rsso_sub8.v */
`timescale 1ns/1ps
// ----------------------------------------
// 8-bit subtract a - b - borrow with flags
// ----------------------------------------
module rsso_sub8 (
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire borrow_i,
  output wire [7:0] diff_o,
  output wire carry_o,
  output wire nib_carry_o,
  output wire zero_o
);
  wire [8:0] full_sum;
  wire [4:0] nib_sum;
  // a + ~b + borrow_i: borrow_i is the carry flag, low means borrow
  assign full_sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, borrow_i};
  assign nib_sum = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, borrow_i};
  assign diff_o = full_sum[7:0];
  assign carry_o = full_sum[8];
  assign nib_carry_o = nib_sum[4];
  assign zero_o = (full_sum[7:0] == 8'h00);
endmodule

/* File: include/rsso_consts.vh */
`ifndef RSSO_CONSTS_VH
`define RSSO_CONSTS_VH
// opcode encodings on the decoded opcode port
`define RSSO_OP_NONE 3'h0
`define RSSO_OP_ROTR 3'h1
`define RSSO_OP_SUBL 3'h2
`define RSSO_OP_SUBF 3'h3
`define RSSO_OP_SUBFB 3'h4
`define RSSO_OP_SLEEP 3'h5
// destination select values
`define RSSO_DEST_WORK 1'b0
`define RSSO_DEST_FILE 1'b1
// reset values
`define RSSO_WORK_RST 8'h00
`define RSSO_FLAG_RST 1'b0
`define RSSO_STAT_N_RST 1'b1
`define RSSO_DOG_CLEAR 8'h00
`define RSSO_PRE_CLEAR 8'h00
// field positions
`define RSSO_MSB 7
`define RSSO_NIB_MSB 3
`endif

/* File: verification/rsso_core_asserts.sv */
`timescale 1ns/1ps
module rsso_core_chk (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire CLK_EN_I,
  input wire EXEC_I,
  input wire [2:0] OPCODE_I,
  input wire [6:0] FILE_ADDR_I,
  input wire DEST_I,
  input wire [7:0] LITERAL_I,
  input wire [7:0] FILE_DATA_I,
  input wire [7:0] WORK_O,
  input wire FILE_WE_O,
  input wire [6:0] FILE_WADDR_O,
  input wire [7:0] FILE_WDATA_O,
  input wire CARRY_O,
  input wire NIBBLE_CARRY_FLAG_O,
  input wire ZERO_O,
  input wire TIMEOUT_STATUS_N_O,
  input wire POWERDOWN_STATUS_N_O,
  input wire [7:0] WATCHDOG_COUNTER_O,
  input wire HALTED_O
);
  reg slp_reg;
  wire [2:0] op = OPCODE_I;
  // halt output lags a cycle, so the cycle after sleep is excluded
  wire go = CLK_EN_I & EXEC_I & !HALTED_O & !slp_reg;
  always @(posedge REF_CLK_I or posedge SYS_RST_I)
    if (SYS_RST_I) slp_reg <= 1'h0;
    else if (CLK_EN_I) slp_reg <= go & (op == 3'h5);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_rot; go && op == 3'h1 |=> CARRY_O == $past(FILE_DATA_I[0]) && $stable(ZERO_O);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate flags");
  property p_dst; go && op == 3'h3 && DEST_I |=> FILE_WE_O && FILE_WADDR_O == $past(FILE_ADDR_I);
  endproperty
  a_dst: assert property (p_dst) else $error("file write");
  property p_subl; go && op == 3'h2 |=> WORK_O == $past(LITERAL_I) - $past(WORK_O); endproperty
  a_subl: assert property (p_subl) else $error("literal diff");
  property p_lc; go && op == 3'h2 |=> CARRY_O == ($past(WORK_O) <= $past(LITERAL_I)); endproperty
  a_lc: assert property (p_lc) else $error("literal carry");
  property p_fdc; go && op == 3'h3 |=>
    NIBBLE_CARRY_FLAG_O == ($past(WORK_O[3:0]) <= $past(FILE_DATA_I[3:0])); endproperty
  a_fdc: assert property (p_fdc) else $error("file nibble carry");
  property p_brw; go && op == 3'h4 && !DEST_I |=>
    WORK_O == $past(FILE_DATA_I) - $past(WORK_O) - !$past(CARRY_O); endproperty
  a_brw: assert property (p_brw) else $error("borrow diff");
  property p_zero; go && op >= 3'h2 && op <= 3'h4 |=>
    ZERO_O == ((FILE_WE_O ? FILE_WDATA_O : WORK_O) == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_slp; go && op == 3'h5 |=>
    !POWERDOWN_STATUS_N_O && TIMEOUT_STATUS_N_O && $stable(CARRY_O); endproperty
  a_slp: assert property (p_slp) else $error("sleep status");
  property p_dog; go && op == 3'h5 |=> ##1 WATCHDOG_COUNTER_O == 8'h00 && HALTED_O; endproperty
  a_dog: assert property (p_dog) else $error("sleep halt");
  c_rot: cover property (go && op == 3'h1);
  c_brw: cover property (go && op == 3'h4 && DEST_I);
  c_slp: cover property (go && op == 3'h5);
endmodule

/* File: verification/rsso_core_test.sv */
`timescale 1ns/1ps
module rsso_core_test;
  logic REF_CLK_I = 1'h0, SYS_RST_I = 1'h1, CLK_EN_I = 1'h1, EXEC_I = 1'h0;
  logic DEST_I = 1'h0, WAKE_I = 1'h0;
  logic [2:0] OPCODE_I = 3'h0;
  logic [6:0] FILE_ADDR_I = 7'h7f;
  logic [7:0] LITERAL_I = 8'h00, FILE_DATA_I = 8'h00;
  wire [7:0] WORK_O, FILE_WDATA_O, WATCHDOG_COUNTER_O, WATCHDOG_PRESCALER_O;
  wire [6:0] FILE_WADDR_O;
  wire FILE_WE_O, CARRY_O, NIBBLE_CARRY_FLAG_O, ZERO_O, TIMEOUT_STATUS_N_O;
  wire POWERDOWN_STATUS_N_O, HALTED_O, OSC_RUN_O;
  int bad_count = 0, check_count = 0, cyc = 0;
  rsso_core DUT (.*);
  initial forever #20 REF_CLK_I = ~REF_CLK_I;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [19:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [11:0] st();
    return {WORK_O, CARRY_O, NIBBLE_CARRY_FLAG_O, ZERO_O, FILE_WE_O};
  endfunction
  // one instruction, results read at the next falling edge
  task automatic op(input logic [2:0] o, input logic d, input logic [7:0] k, f);
    @(negedge REF_CLK_I);
    {EXEC_I, OPCODE_I, DEST_I, LITERAL_I, FILE_DATA_I} = {1'h1, o, d, k, f};
    @(negedge REF_CLK_I);
    EXEC_I = 1'h0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 500) begin
      bad_count++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_alu;
    op(3'h1, 1'h1, 8'h00, 8'h81);
    chk("rot wr", {FILE_WE_O, FILE_WADDR_O, FILE_WDATA_O}, 16'hff40);
    op(3'h1, 1'h0, 8'h00, 8'h02);
    chk("rot w", st(), 16'h0810);
    op(3'h2, 1'h1, 8'h81, 8'h00);
    chk("subl a", st(), 16'h000e);
    op(3'h2, 1'h0, 8'h05, 8'h00);
    chk("subl b", st(), 16'h005c);
    op(3'h2, 1'h0, 8'h03, 8'h00);
    chk("subl c", st(), 16'h0fe0);
    FILE_ADDR_I = 7'h05;
    op(3'h3, 1'h1, 8'h00, 8'hfe);
    chk("subf a", {st(), FILE_WDATA_O}, 20'hfef00);
    chk("subf addr", FILE_WADDR_O, 16'h0005);
    op(3'h3, 1'h0, 8'h00, 8'h10);
    chk("subf b", st(), 16'h0120);
    op(3'h4, 1'h0, 8'h00, 8'h12);
    chk("brw a", st(), 16'h0ff0);
    op(3'h4, 1'h1, 8'h00, 8'h00);
    chk("brw b", {st(), FILE_WDATA_O}, 20'hff300);
    op(3'h3, 1'h0, 8'h00, 8'hff);
    op(3'h4, 1'h0, 8'h00, 8'h05);
    chk("brw c", st(), 16'h005c);
    $display("alu test done");
  endtask
  task automatic t_slp;
    op(3'h5, 1'h0, 8'h00, 8'h00);
    chk("status", {TIMEOUT_STATUS_N_O, POWERDOWN_STATUS_N_O, st()}, 16'h205c);
    @(negedge REF_CLK_I);
    chk("halt", {HALTED_O, OSC_RUN_O}, 16'h0002);
    chk("watchdog", {WATCHDOG_COUNTER_O, WATCHDOG_PRESCALER_O}, 16'h0000);
    op(3'h2, 1'h0, 8'h07, 8'h00);
    chk("asleep", st(), 16'h005c);
    WAKE_I = 1'h1;
    @(negedge REF_CLK_I);
    WAKE_I = 1'h0;
    repeat (2) @(negedge REF_CLK_I);
    chk("wake", {HALTED_O, OSC_RUN_O}, 16'h0001);
    op(3'h2, 1'h0, 8'h07, 8'h00);
    chk("resume", st(), 16'h002c);
    $display("sleep test done");
  endtask
  // enable low must swallow an instruction whole
  task automatic t_ce;
    CLK_EN_I = 1'h0;
    op(3'h2, 1'h0, 8'h00, 8'h00);
    chk("frozen", st(), 16'h002c);
    CLK_EN_I = 1'h1;
    op(3'h2, 1'h0, 8'h00, 8'h00);
    chk("thawed", st(), 16'h0fe0);
    $display("enable test done");
  endtask
  initial begin
    repeat (4) @(negedge REF_CLK_I);
    SYS_RST_I = 1'h0;
    t_alu;
    t_slp;
    t_ce;
    print_verdict;
  end
endmodule
bind rsso_core rsso_core_chk chk (.*);
